// file: hw/gpe_edge_irq.sv
// GPIO pull, edge detection and interrupt logic for a 16-line expander
// Operation
// - Pull-up enable bit 1 enables pin pull-up, 0 disables; resets to zero.
// - Pull-down enable bit 1 enables pin pull-down, 0 disables; resets to zero.
// - Mask bit 0 lets events interrupt, 1 blocks; masks reset to 0xFF.
// - Only input-direction pins can raise the interrupt output.
// - Two-bit sensitivity: 00 none, 01 rising, 10 falling, 11 both.
// - Each sensitivity register packs four pins, highest pin in bits 7:6.
// - Matching edge sets the pin event flag, held until cleared.
// - Matching edge on unmasked input pin sets interrupt source flag, held until cleared.
// - Writing 1 to source bit clears it and the pin event flag.
// - Writing 1 to event bit clears it and the pin source flag.
// - Interrupt output returns high only when all source bits are clear.
// - Changing a pin sensitivity clears its event and source flags.
// - Direction bit 1 means input, 0 means output.
`include "gpe_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module gpe_edge_irq #(
    parameter int NPINS = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire gpe_pkg::gpe_reg_req_s regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [NPINS-1:0] pinIn,
    output logic [NPINS-1:0] pullUpEn,
    output logic [NPINS-1:0] pullDownEn,
    output logic [NPINS-1:0] pinIsInput,
    output logic irqOutN,
    output logic irqPinOut,
    output logic irqPinOeN
);
    import gpe_pkg::*;

    // ======================================================================
    // Registers
    logic [NPINS-1:0] dir_q;
    logic [NPINS-1:0] pullUp_q;
    logic [NPINS-1:0] pullDn_q;
    logic [NPINS-1:0] mask_q;
    logic [2*NPINS-1:0] sense_q;
    logic [NPINS-1:0] evt_q;
    logic [NPINS-1:0] evt_d;
    logic [NPINS-1:0] org_q;
    logic [NPINS-1:0] org_d;
    logic irqN_q;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic [NPINS-1:0] sync1_q;
    logic [NPINS-1:0] sync2_q;
    logic [NPINS-1:0] prev_q;

    // ======================================================================
    // Write decode
    wire logic wr = regReq.wrEn;
    wire logic [7:0] wa = regReq.addr;
    wire logic [7:0] wd = regReq.wrData;
    wire logic wrDirB = wr && (wa == `GPE_ADDR_DIR_B);
    wire logic wrDirA = wr && (wa == `GPE_ADDR_DIR_A);
    wire logic wrPuB = wr && (wa == `GPE_ADDR_PULLUP_B);
    wire logic wrPuA = wr && (wa == `GPE_ADDR_PULLUP_A);
    wire logic wrPdB = wr && (wa == `GPE_ADDR_PULLDN_B);
    wire logic wrPdA = wr && (wa == `GPE_ADDR_PULLDN_A);
    wire logic wrMaskB = wr && (wa == `GPE_ADDR_MASK_B);
    wire logic wrMaskA = wr && (wa == `GPE_ADDR_MASK_A);
    wire logic wrOrgB = wr && (wa == `GPE_ADDR_ORIGIN_B);
    wire logic wrOrgA = wr && (wa == `GPE_ADDR_ORIGIN_A);
    wire logic wrEvtB = wr && (wa == `GPE_ADDR_EVENT_B);
    wire logic wrEvtA = wr && (wa == `GPE_ADDR_EVENT_A);
    // Sense groups in pin order: 3:0, 7:4, 11:8, 15:12
    wire logic [3:0] wrSense = {
        wr && (wa == `GPE_ADDR_SENSE_HI_B),
        wr && (wa == `GPE_ADDR_SENSE_LO_B),
        wr && (wa == `GPE_ADDR_SENSE_HI_A),
        wr && (wa == `GPE_ADDR_SENSE_LO_A)
    };
    // Write-one-to-clear masks; zero bits leave flags alone
    wire logic [NPINS-1:0] orgW1c = {wrOrgB ? wd : 8'h00, wrOrgA ? wd : 8'h00};
    wire logic [NPINS-1:0] evtW1c = {wrEvtB ? wd : 8'h00, wrEvtA ? wd : 8'h00};

    // ======================================================================
    // Per-pin edge detection and flag update
    logic [NPINS-1:0] hit;
    logic [NPINS-1:0] senseChg;
    logic [NPINS-1:0] clr;
    // Decoded sensitivity per pin from the enum codes; read only by the checks
    logic [NPINS-1:0] senseNone;
    logic [NPINS-1:0] senseRise;
    logic [NPINS-1:0] senseFall;
    logic [NPINS-1:0] senseBoth;
    genvar p;
    generate
        for (p = 0; p < NPINS; p++) begin : gPin
            wire logic [1:0] sel = sense_q[2*p +: 2];
            wire logic rise = sync2_q[p] && !prev_q[p];
            wire logic fall = !sync2_q[p] && prev_q[p];
            assign hit[p] = (sel[`GPE_SENSE_RISE_BIT] && rise)
                || (sel[`GPE_SENSE_FALL_BIT] && fall);
            assign senseChg[p] = wrSense[p/4] && (wd[2*(p%4) +: 2] != sel);
            assign clr[p] = orgW1c[p] || evtW1c[p] || senseChg[p];
            // A new edge wins over a clear in the same cycle
            assign evt_d[p] = hit[p] || (evt_q[p] && !clr[p]);
            assign org_d[p] = (hit[p] && dir_q[p] && !mask_q[p])
                || (org_q[p] && !clr[p]);
            // Enum codes give the checks a decode of their own
            assign senseNone[p] = (sel == GPE_SENSE_NONE);
            assign senseRise[p] = (sel == GPE_SENSE_RISE);
            assign senseFall[p] = (sel == GPE_SENSE_FALL);
            assign senseBoth[p] = (sel == GPE_SENSE_BOTH);
        end
    endgenerate

    // ======================================================================
    // Pin synchronisers; only the second stage and its delayed copy prev_q are looked at
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ======================================================================
    // Configuration registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_q <= {`GPE_RST_DIR, `GPE_RST_DIR};
            pullUp_q <= {`GPE_RST_ZERO, `GPE_RST_ZERO};
            pullDn_q <= {`GPE_RST_ZERO, `GPE_RST_ZERO};
            mask_q <= {`GPE_RST_MASK, `GPE_RST_MASK};
            sense_q <= '0;
        end else begin
            if (wrDirB) dir_q[15:8] <= wd;
            if (wrDirA) dir_q[7:0] <= wd;
            if (wrPuB) pullUp_q[15:8] <= wd;
            if (wrPuA) pullUp_q[7:0] <= wd;
            if (wrPdB) pullDn_q[15:8] <= wd;
            if (wrPdA) pullDn_q[7:0] <= wd;
            if (wrMaskB) mask_q[15:8] <= wd;
            if (wrMaskA) mask_q[7:0] <= wd;
            if (wrSense[0]) sense_q[7:0] <= wd;
            if (wrSense[1]) sense_q[15:8] <= wd;
            if (wrSense[2]) sense_q[23:16] <= wd;
            if (wrSense[3]) sense_q[31:24] <= wd;
        end
    end

    // ======================================================================
    // Status flags and interrupt pin
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_q <= '0;
            org_q <= '0;
            irqN_q <= 1'b1;
        end else begin
            evt_q <= evt_d;
            org_q <= org_d;
            irqN_q <= ~|org_q;
        end
    end

    // ======================================================================
    // Read port, one cycle latency; unmapped offsets read zero
    wire logic [7:0] ra = regReq.addr;
    wire logic [7:0] rdMux =
        (ra == `GPE_ADDR_DIR_B) ? dir_q[15:8] :
        (ra == `GPE_ADDR_DIR_A) ? dir_q[7:0] :
        (ra == `GPE_ADDR_PULLUP_B) ? pullUp_q[15:8] :
        (ra == `GPE_ADDR_PULLUP_A) ? pullUp_q[7:0] :
        (ra == `GPE_ADDR_PULLDN_B) ? pullDn_q[15:8] :
        (ra == `GPE_ADDR_PULLDN_A) ? pullDn_q[7:0] :
        (ra == `GPE_ADDR_MASK_B) ? mask_q[15:8] :
        (ra == `GPE_ADDR_MASK_A) ? mask_q[7:0] :
        (ra == `GPE_ADDR_SENSE_HI_B) ? sense_q[31:24] :
        (ra == `GPE_ADDR_SENSE_HI_A) ? sense_q[15:8] :
        (ra == `GPE_ADDR_SENSE_LO_B) ? sense_q[23:16] :
        (ra == `GPE_ADDR_SENSE_LO_A) ? sense_q[7:0] :
        (ra == `GPE_ADDR_ORIGIN_B) ? org_q[15:8] :
        (ra == `GPE_ADDR_ORIGIN_A) ? org_q[7:0] :
        (ra == `GPE_ADDR_EVENT_B) ? evt_q[15:8] :
        (ra == `GPE_ADDR_EVENT_A) ? evt_q[7:0] :
        `GPE_RD_UNMAPPED;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= `GPE_RST_ZERO;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= regReq.rdEn;
            if (regReq.rdEn) rdData_q <= rdMux;
        end
    end

    // ======================================================================
    // Outputs
    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign pullUpEn = pullUp_q;
    assign pullDownEn = pullDn_q;
    assign pinIsInput = dir_q;
    assign irqOutN = irqN_q;
    // Open drain: pull low only, enable is active low
    assign irqPinOut = 1'b0;
    assign irqPinOeN = irqN_q;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence sOrgClearA;
        wrOrgA && (wd != 8'h00);
    endsequence

    sequence sEvtClearA;
        wrEvtA && (wd != 8'h00);
    endsequence

    pull_up_follow_a: assert property (wrPuA |=> pullUpEn[7:0] == $past(wd))
        else $error("pull-up enable did not follow write");
    pull_dn_follow_a: assert property (wrPdB |=> pullDownEn[15:8] == $past(wd))
        else $error("pull-down enable did not follow write");
    masked_no_origin_a: assert property (
        ##1 ((org_q & ~$past(org_q)) & ($past(mask_q) | ~$past(dir_q))) == '0)
        else $error("origin flag set on masked or output pin");
    event_sets_a: assert property (|hit |=> (evt_q & $past(hit)) == $past(hit))
        else $error("edge did not set event flag");
    origin_sets_a: assert property (|(hit & dir_q & ~mask_q)
        |=> (org_q & $past(hit & dir_q & ~mask_q))
        == $past(hit & dir_q & ~mask_q))
        else $error("unmasked edge did not set origin flag");
    origin_clear_a: assert property (sOrgClearA and ((hit[7:0] & wd) == 8'h00)
        |=> (evt_q[7:0] & $past(wd)) == 8'h00 && (org_q[7:0] & $past(wd)) == 8'h00)
        else $error("origin write-one did not clear both flags");
    event_clear_a: assert property (sEvtClearA and ((hit[7:0] & wd) == 8'h00)
        |=> (org_q[7:0] & $past(wd)) == 8'h00 && (evt_q[7:0] & $past(wd)) == 8'h00)
        else $error("event write-one did not clear both flags");
    irq_release_a: assert property ($rose(irqOutN) |-> $past(org_q) == '0)
        else $error("interrupt released with source pending");
    sense_change_a: assert property (senseChg[0] && !hit[0] |=> !evt_q[0] && !org_q[0])
        else $error("sensitivity change did not clear flags");
    irq_assert_a: assert property (org_q != '0 |=> !irqOutN ##0 !irqPinOeN)
        else $error("interrupt not driven while source set");
    zero_write_a: assert property (wrEvtA && wd == 8'h00
        |=> (evt_q[7:0] & $past(evt_q[7:0])) == $past(evt_q[7:0]))
        else $error("zero write changed event flags");

    // ======================================================================
    // Sensitivity decode, field layout, flag holding and the interrupt pin
    // Edges rebuilt from the synchroniser flops, apart from the per-pin decode
    wire logic [NPINS-1:0] riseV = sync2_q & ~prev_q;
    wire logic [NPINS-1:0] fallV = ~sync2_q & prev_q;

    sequence sOrgClearB;
        wrOrgB && (wd != 8'h00);
    endsequence

    // First source flag after a quiet cycle
    sequence sOriginRaised;
        (org_q == '0) ##1 (org_q != '0);
    endsequence

    sense_none_a: assert property ((hit & senseNone) == '0)
        else $error("edge detected on pin with no sensitivity");
    sense_rise_a: assert property ((hit & senseRise) == (riseV & senseRise))
        else $error("rising sensitivity mismatch");
    sense_fall_a: assert property ((hit & senseFall) == (fallV & senseFall))
        else $error("falling sensitivity mismatch");
    sense_both_a: assert property (
        (hit & senseBoth) == ((riseV | fallV) & senseBoth))
        else $error("both-edge sensitivity mismatch");
    sense_pack_hi_a: assert property (wr && wa == `GPE_ADDR_SENSE_HI_B
        |=> sense_q[31:30] == $past(wd[7:6]) && sense_q[25:24] == $past(wd[1:0]))
        else $error("upper sensitivity field landed on wrong pin");
    sense_pack_lo_a: assert property (wr && wa == `GPE_ADDR_SENSE_LO_A
        |=> sense_q[7:6] == $past(wd[7:6]) && sense_q[1:0] == $past(wd[1:0]))
        else $error("lower sensitivity field landed on wrong pin");
    mask_follow_a: assert property (wrMaskB |=> mask_q[15:8] == $past(wd))
        else $error("mask did not follow write");
    dir_follow_a: assert property (wrDirA |=> pinIsInput[7:0] == $past(wd))
        else $error("direction did not follow write");
    pull_up_b_a: assert property (wrPuB |=> pullUpEn[15:8] == $past(wd))
        else $error("bank B pull-up enable did not follow write");
    event_hold_a: assert property (!wr
        |=> (evt_q & $past(evt_q)) == $past(evt_q))
        else $error("event flag dropped without a write");
    origin_hold_a: assert property (!wr
        |=> (org_q & $past(org_q)) == $past(org_q))
        else $error("origin flag dropped without a write");
    origin_clear_b_a: assert property (sOrgClearB and ((hit[15:8] & wd) == 8'h00)
        |=> (evt_q[15:8] & $past(wd)) == 8'h00 && (org_q[15:8] & $past(wd)) == 8'h00)
        else $error("bank B origin write-one did not clear both flags");
    irq_fall_a: assert property (sOriginRaised |=> !irqOutN)
        else $error("interrupt not raised after first source flag");
    irq_high_a: assert property (org_q == '0 |=> irqOutN)
        else $error("interrupt held with no source pending");
endmodule
`default_nettype wire

// file: hw/gpe_pkg.sv
// Types shared by the GPIO edge interrupt block
package gpe_pkg;
    typedef enum logic [1:0] {
        GPE_SENSE_NONE,
        GPE_SENSE_RISE,
        GPE_SENSE_FALL,
        GPE_SENSE_BOTH
    } gpe_sense_e;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } gpe_reg_req_s;
endpackage

// file: hw/gpe_regs.svh
// Register offsets, reset values and field layout of the GPIO edge interrupt block
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH

// ==========================================================================
// Register offsets
`define GPE_ADDR_DIR_B 8'h02
`define GPE_ADDR_DIR_A 8'h03
`define GPE_ADDR_PULLUP_B 8'h04
`define GPE_ADDR_PULLUP_A 8'h05
`define GPE_ADDR_PULLDN_B 8'h06
`define GPE_ADDR_PULLDN_A 8'h07
`define GPE_ADDR_MASK_B 8'h08
`define GPE_ADDR_MASK_A 8'h09
`define GPE_ADDR_SENSE_HI_B 8'h0A
`define GPE_ADDR_SENSE_HI_A 8'h0B
`define GPE_ADDR_SENSE_LO_B 8'h0C
`define GPE_ADDR_SENSE_LO_A 8'h0D
`define GPE_ADDR_ORIGIN_B 8'h0E
`define GPE_ADDR_ORIGIN_A 8'h0F
`define GPE_ADDR_EVENT_B 8'h10
`define GPE_ADDR_EVENT_A 8'h11

// ==========================================================================
// Reset values
`define GPE_RST_DIR 8'hFF
`define GPE_RST_MASK 8'hFF
`define GPE_RST_ZERO 8'h00
`define GPE_RD_UNMAPPED 8'h00

// ==========================================================================
// Edge sensitivity field: bit 0 rising, bit 1 falling
`define GPE_SENSE_W 2
`define GPE_SENSE_RISE_BIT 0
`define GPE_SENSE_FALL_BIT 1

`endif

// file: verification/gpe_host_model.sv
// Host-side register master model for the GPIO edge interrupt block
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Register master
module gpe_host_model (
    input wire logic core_clk,
    output var gpe_pkg::gpe_reg_req_s regReq
);
    import gpe_pkg::*;
    logic [7:0] expQ[$];

    initial regReq = '0;

    // Each request lasts one cycle; an idle edge follows so no signal is assigned twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        regReq <= '0;
        @(posedge core_clk);
    endtask

    // Expected data is noted before the request so the watcher never finds the queue empty
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(posedge core_clk);
        regReq <= '0;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: verification/test_gpe_edge_irq.sv
// Self-checking bench of the GPIO edge interrupt block
`include "gpe_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    nTests++; \
    if ((gt) !== (ex)) begin \
        errorCnt++; \
        $display("[ERR] %s exp %0h got %0h", nm, ex, gt); \
    end \
end

module test_gpe_edge_irq;
    import gpe_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] pinIn = 16'h0000;
    gpe_reg_req_s regReq;
    logic [7:0] regRdData, expV, rv, bm, sa, ea, oa;
    logic regRdValid, irqOutN, irqPinOut, irqPinOeN;
    logic [15:0] pullUpEn, pullDownEn, pinIsInput;
    wire logic [31:0] pulls = {pullUpEn, pullDownEn};
    int errorCnt = 0, nTests = 0, seed = 59, cyc = 0, p;

    always #10 core_clk = ~core_clk;

    gpe_host_model host (.core_clk(core_clk), .regReq(regReq));

    gpe_edge_irq #(.NPINS(16)) DUT (.core_clk(core_clk), .arst_n(arst_n), .regReq(regReq),
        .regRdData(regRdData), .regRdValid(regRdValid), .pinIn(pinIn), .pullUpEn(pullUpEn),
        .pullDownEn(pullDownEn), .pinIsInput(pinIsInput), .irqOutN(irqOutN),
        .irqPinOut(irqPinOut), .irqPinOeN(irqPinOeN));

    task automatic endOfTest();
        if (errorCnt == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // Timeout and read watcher
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            endOfTest();
        end
    end

    always @(posedge core_clk) begin
        if (regRdValid === 1'b1) begin
            expV = host.expQ.pop_front();
            `CHK("regRdData", expV, regRdData)
        end
    end

    // ==========================================
    // Helpers
    task automatic pickPin();
        p = $unsigned($random(seed)) % 16;
        bm = 8'h01 << (p % 8);
        sa = p[3] ? (p[2] ? `GPE_ADDR_SENSE_HI_B : `GPE_ADDR_SENSE_LO_B)
                  : (p[2] ? `GPE_ADDR_SENSE_HI_A : `GPE_ADDR_SENSE_LO_A);
        ea = p[3] ? `GPE_ADDR_EVENT_B : `GPE_ADDR_EVENT_A;
        oa = p[3] ? `GPE_ADDR_ORIGIN_B : `GPE_ADDR_ORIGIN_A;
    endtask

    // Pins pass two sync flops, so five cycles cover the flag and irq latency
    task automatic pinSet(input logic v);
        pinIn[p] <= v;
        repeat (5) @(posedge core_clk);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        `CHK("pullUpEn", 16'h0000, pullUpEn)
        `CHK("pullDownEn", 16'h0000, pullDownEn)
        `CHK("pinIsInput", 16'hFFFF, pinIsInput)
        `CHK("irqOutN", 1'b1, irqOutN)
        `CHK("irqPinOeN", 1'b1, irqPinOeN)
        `CHK("irqPinOut", 1'b0, irqPinOut)
        for (int a = 2; a < 18; a++) begin
            host.rd(a[7:0], (a == 2 || a == 3 || a == 8 || a == 9) ? 8'hFF : 8'h00);
        end
        host.rd(8'h40, `GPE_RD_UNMAPPED);
        for (int i = 0; i < 4; i++) begin
            rv = $random(seed);
            host.wr(8'h04 + i[7:0], rv);
            host.rd(8'h04 + i[7:0], rv);
            `CHK("pulls", rv, pulls[31-8*i -: 8])
        end
        host.wr(`GPE_ADDR_MASK_B, 8'h00);
        host.wr(`GPE_ADDR_MASK_A, 8'h00);
        // Every sensitivity code on a random pin, then clear by either register
        for (int m = 0; m < 4; m++) begin
            pickPin();
            host.wr(sa, 8'(m) << (2 * (p % 4)));
            pinSet(1'b1);
            host.rd(ea, m[0] ? bm : 8'h00);
            pinSet(1'b0);
            rv = (m != 0) ? bm : 8'h00;
            host.rd(oa, rv);
            `CHK("irqOutN", ~|rv, irqOutN)
            `CHK("irqPinOeN", ~|rv, irqPinOeN)
            `CHK("irqPinOut", 1'b0, irqPinOut)
            host.wr(oa, 8'h00);
            host.rd(ea, rv);
            host.wr(m[0] ? ea : oa, rv);
            host.rd(ea, 8'h00);
            host.rd(oa, 8'h00);
            `CHK("irqOutN", 1'b1, irqOutN)
        end
        // Masked pin, sensitivity change, then an output-direction pin
        pickPin();
        host.wr(p[3] ? `GPE_ADDR_MASK_B : `GPE_ADDR_MASK_A, bm);
        host.wr(sa, 8'(3) << (2 * (p % 4)));
        pinSet(1'b1);
        host.rd(ea, bm);
        host.rd(oa, 8'h00);
        `CHK("irqOutN", 1'b1, irqOutN)
        host.wr(sa, 8'(1) << (2 * (p % 4)));
        host.rd(ea, 8'h00);
        host.wr(p[3] ? `GPE_ADDR_MASK_B : `GPE_ADDR_MASK_A, 8'h00);
        host.wr(p[3] ? `GPE_ADDR_DIR_B : `GPE_ADDR_DIR_A, ~bm);
        `CHK("pinIsInput", 1'b0, pinIsInput[p])
        pinSet(1'b0);
        pinSet(1'b1);
        host.rd(ea, bm);
        host.rd(oa, 8'h00);
        `CHK("irqOutN", 1'b1, irqOutN)
        repeat (3) @(posedge core_clk);
        `CHK("readQueue", 0, host.expQ.size())
        endOfTest();
    end
endmodule
`default_nettype wire
